/* design/uvpc_pkg.sv */
// Package of constants and types shared by the EPROM programmer controller.
package uvpc_pkg;

  // Clock rate in kHz; the reference clock runs at 200 MHz.
  localparam int CLK_KHZ = 200000;
  // Nominal initial pulse width in microseconds.
  localparam int INIT_PULSE_US = 1000;
  // Cycles per millisecond tick.
  localparam int TICK_CYCLES = CLK_KHZ * INIT_PULSE_US / 1000;
  // Setup and hold time around pulses in microseconds.
  localparam int SETUP_US = 2;
  // Setup time in cycles, rounded up.
  localparam int SETUP_CYCLES = (SETUP_US * CLK_KHZ + 999) / 1000;
  // Verify data delay in nanoseconds.
  localparam int VERIFY_NS = 150;
  // Verify delay in cycles, rounded up.
  localparam int VERIFY_CYCLES = (VERIFY_NS * (CLK_KHZ / 1000) + 999) / 1000;
  // Most initial pulses per byte.
  localparam int MAX_PULSES = 25;
  // Overprogram multiplier.
  localparam int OVER_FACTOR = 3;
  // Width of the data bus.
  localparam int DATA_W = 8;
  // Width of the address bus.
  localparam int ADDR_W = 15;
  // Bit position of the identifier high voltage line.
  localparam int ID_HV_BIT = 9;
  // Bit position of the identifier byte select line.
  localparam int ID_SEL_BIT = 0;

  // Controller states.
  typedef enum logic [3:0] {
    UVPC_IDLE,
    UVPC_SETUP,
    UVPC_PULSE,
    UVPC_HOLD,
    UVPC_VSETUP,
    UVPC_VWAIT,
    UVPC_OVER,
    UVPC_RB_WAIT,
    UVPC_ID_WAIT,
    UVPC_DONE
  } uvpc_state_type;

endpackage : uvpc_pkg

/* design/uvpc_programmer.sv */
// Programmer controller that drives a UV EPROM through its pins.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Erased cells read as one.
// RULE2 - Programming only clears bits; erase restores.
// RULE3 - Program mode: high supply, select low.
// RULE4 - Initial pulse is 1 ms select low.
// RULE5 - Overprogram pulse lasts three X milliseconds.
// RULE6 - Allow up to 25 initial pulses.
// RULE7 - Hold 6.0 V main, 12.5 V program supply.
// RULE8 - Final readback at 5.0 V compares data.
// RULE9 - Select high inhibits programming.
// RULE10 - Select low pulse programs one device.
// RULE11 - Verify each byte after pulsing.
// RULE12 - Verify: gate low, select high, delay.
// RULE13 - Identifier mode needs high voltage line.
// RULE14 - Byte select picks maker or type code.
// RULE15 - Other address lines low for identifier.
// RULE16 - Verify passes only when byte programmed.
// RULE17 - Initial pulse within five percent.
// RULE18 - Overprogram between 2.85 and 78.75 ms.
// RULE19 - Reset count per byte, report failure.
// RULE20 - Address and data stable per byte.
module uvpc_programmer #(
  parameter int TICK_LEN = uvpc_pkg::TICK_CYCLES,
  parameter int MAX_PULSES = uvpc_pkg::MAX_PULSES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic prog_start_i,
  input wire logic read_start_i,
  input wire logic id_start_i,
  input wire logic id_sel_i,
  input wire logic [uvpc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [uvpc_pkg::DATA_W-1:0] data_i,
  input wire logic [uvpc_pkg::DATA_W-1:0] mem_data_i,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic [uvpc_pkg::DATA_W-1:0] rdata_o,
  output logic [4:0] pulses_o,
  output logic chip_sel_n_o,
  output logic out_gate_n_o,
  output logic [uvpc_pkg::ADDR_W-1:0] mem_addr_o,
  output logic id_hv_en_o,
  output logic [uvpc_pkg::DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_o,
  output logic vpp_high_o,
  output logic vcc_prog_o
);

  // Millisecond timer link.
  uvpc_tick_if tk ();

  uvpc_timer #(
    .TICK_LEN(TICK_LEN)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .tk(tk)
  );

  // Two-flop synchroniser on the data pins coming back from the memory.
  logic [uvpc_pkg::DATA_W-1:0] din_meta_r;
  logic [uvpc_pkg::DATA_W-1:0] din_sync_r;

  // State and working registers with their next values.
  uvpc_pkg::uvpc_state_type state_r;
  uvpc_pkg::uvpc_state_type state_nxt;
  // Pulse count X for the current byte.
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  // Milliseconds elapsed in the current overprogram pulse.
  logic [6:0] ms_r;
  logic [6:0] ms_nxt;
  // Latched address and data.
  logic [uvpc_pkg::ADDR_W-1:0] addr_r;
  logic [uvpc_pkg::ADDR_W-1:0] addr_nxt;
  logic [uvpc_pkg::DATA_W-1:0] data_r;
  logic [uvpc_pkg::DATA_W-1:0] data_nxt;
  // Pin and status registers.
  logic cs_n_r;
  logic cs_n_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic dq_oe_r;
  logic dq_oe_nxt;
  logic hv_r;
  logic hv_nxt;
  logic vpp_r;
  logic vpp_nxt;
  logic vccp_r;
  logic vccp_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;
  logic fail_r;
  logic fail_nxt;
  logic [uvpc_pkg::DATA_W-1:0] rdata_r;
  logic [uvpc_pkg::DATA_W-1:0] rdata_nxt;
  // Restart request for the timer.
  logic clr_nxt;

  assign tk.clear = clr_nxt;

  // Sequencer: computes next state, pins and status.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ms_nxt = ms_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    cs_n_nxt = cs_n_r;
    oe_n_nxt = oe_n_r;
    dq_oe_nxt = dq_oe_r;
    hv_nxt = hv_r;
    vpp_nxt = vpp_r;
    vccp_nxt = vccp_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    fail_nxt = fail_r;
    rdata_nxt = rdata_r;
    clr_nxt = 1'b0;
    case (state_r)
      uvpc_pkg::UVPC_IDLE:
      begin
        if (prog_start_i)
        begin
          // New byte: latch address and data, clear the pulse count.
          addr_nxt = addr_i; // RULE20
          data_nxt = data_i; // RULE20
          cnt_nxt = 5'h00; // RULE19
          fail_nxt = 1'b0;
          vpp_nxt = 1'b1; // RULE7
          vccp_nxt = 1'b1; // RULE7
          dq_oe_nxt = 1'b1; // RULE3
          busy_nxt = 1'b1;
          clr_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_SETUP;
        end
        else if (read_start_i)
        begin
          // Readback at normal supply with select and gate low.
          addr_nxt = addr_i;
          vpp_nxt = 1'b0;
          vccp_nxt = 1'b0; // RULE8
          cs_n_nxt = 1'b0;
          oe_n_nxt = 1'b0;
          busy_nxt = 1'b1;
          clr_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_RB_WAIT;
        end
        else if (id_start_i)
        begin
          // Identifier read: every other address line held low.
          addr_nxt = '0; // RULE15
          addr_nxt[uvpc_pkg::ID_SEL_BIT] = id_sel_i; // RULE14
          hv_nxt = 1'b1; // RULE13
          cs_n_nxt = 1'b0;
          oe_n_nxt = 1'b0;
          busy_nxt = 1'b1;
          clr_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_ID_WAIT;
        end
      end
      uvpc_pkg::UVPC_SETUP:
      begin
        // Supplies, address and data settle before the select falls.
        if (tk.cycles >= 18'(uvpc_pkg::SETUP_CYCLES))
        begin
          cs_n_nxt = 1'b0; // RULE10
          ms_nxt = 7'h00;
          clr_nxt = 1'b1;
          cnt_nxt = cnt_r + 5'h01;
          state_nxt = uvpc_pkg::UVPC_PULSE;
        end
      end
      uvpc_pkg::UVPC_PULSE:
      begin
        // Initial pulse of one tick plus one cycle; that width meets the tolerance.
        if (tk.tick)
        begin
          cs_n_nxt = 1'b1; // RULE4 RULE17
          clr_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_HOLD;
        end
      end
      uvpc_pkg::UVPC_HOLD:
      begin
        // Data hold after the pulse, then release the bus for verify.
        if (tk.cycles >= 18'(uvpc_pkg::SETUP_CYCLES))
        begin
          dq_oe_nxt = 1'b0;
          clr_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_VSETUP;
        end
      end
      uvpc_pkg::UVPC_VSETUP:
      begin
        // Gate falls with select high and high supply kept.
        if (tk.cycles >= 18'(uvpc_pkg::SETUP_CYCLES))
        begin
          oe_n_nxt = 1'b0; // RULE12
          clr_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_VWAIT;
        end
      end
      uvpc_pkg::UVPC_VWAIT:
      begin
        // Sample after the verify delay plus synchroniser latency.
        if (tk.cycles >= 18'(uvpc_pkg::VERIFY_CYCLES + 2))
        begin
          oe_n_nxt = 1'b1;
          dq_oe_nxt = 1'b1;
          clr_nxt = 1'b1;
          rdata_nxt = din_sync_r;
          if (din_sync_r == data_r) // RULE11 RULE16
          begin
            cs_n_nxt = 1'b0; // RULE5
            ms_nxt = 7'h00;
            state_nxt = uvpc_pkg::UVPC_OVER;
          end
          else if (cnt_r >= 5'(MAX_PULSES)) // RULE6
          begin
            fail_nxt = 1'b1; // RULE19
            dq_oe_nxt = 1'b0;
            vpp_nxt = 1'b0;
            vccp_nxt = 1'b0;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            state_nxt = uvpc_pkg::UVPC_IDLE;
          end
          else
          begin
            state_nxt = uvpc_pkg::UVPC_SETUP;
          end
        end
      end
      uvpc_pkg::UVPC_OVER:
      begin
        // Overprogram lasts three times X milliseconds.
        if (tk.tick)
        begin
          ms_nxt = ms_r + 7'h01;
          if (ms_nxt == 7'(uvpc_pkg::OVER_FACTOR * cnt_r)) // RULE5 RULE18
          begin
            // Select rises first; data and supplies stay for the hold time.
            cs_n_nxt = 1'b1;
            clr_nxt = 1'b1;
            state_nxt = uvpc_pkg::UVPC_DONE;
          end
        end
      end
      uvpc_pkg::UVPC_DONE:
      begin
        // Data hold after the overprogram pulse, then release pins and supplies.
        if (tk.cycles >= 18'(uvpc_pkg::SETUP_CYCLES))
        begin
          dq_oe_nxt = 1'b0; // RULE20
          vpp_nxt = 1'b0;
          vccp_nxt = 1'b0;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_IDLE;
        end
      end
      uvpc_pkg::UVPC_RB_WAIT, uvpc_pkg::UVPC_ID_WAIT:
      begin
        // Access time plus synchroniser latency, then capture.
        if (tk.cycles >= 18'(uvpc_pkg::VERIFY_CYCLES + 2))
        begin
          rdata_nxt = din_sync_r;
          cs_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          hv_nxt = 1'b0;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = uvpc_pkg::UVPC_IDLE;
        end
      end
      default:
      begin
        state_nxt = uvpc_pkg::UVPC_IDLE;
      end
    endcase
  end

  // Registers of the sequencer and the input synchroniser.
  always_ff @(posedge ref_clk_i)
  begin
    din_meta_r <= mem_data_i;
    din_sync_r <= din_meta_r;
    if (!resetn_i)
    begin
      state_r <= uvpc_pkg::UVPC_IDLE;
      cnt_r <= 5'h00;
      ms_r <= 7'h00;
      addr_r <= '0;
      data_r <= 8'hFF;
      cs_n_r <= 1'b1; // RULE9
      oe_n_r <= 1'b1;
      dq_oe_r <= 1'b0;
      hv_r <= 1'b0;
      vpp_r <= 1'b0;
      vccp_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ms_r <= ms_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      cs_n_r <= cs_n_nxt;
      oe_n_r <= oe_n_nxt;
      dq_oe_r <= dq_oe_nxt;
      hv_r <= hv_nxt;
      vpp_r <= vpp_nxt;
      vccp_r <= vccp_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs come straight from registers.
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign fail_o = fail_r;
  assign rdata_o = rdata_r;
  assign pulses_o = cnt_r;
  assign chip_sel_n_o = cs_n_r;
  assign out_gate_n_o = oe_n_r;
  assign mem_addr_o = addr_r;
  assign id_hv_en_o = hv_r;
  assign mem_data_o = data_r;
  assign mem_data_oe_o = dq_oe_r;
  assign vpp_high_o = vpp_r;
  assign vcc_prog_o = vccp_r;

endmodule : uvpc_programmer

/* design/uvpc_tick_if.sv */
// Interface carrying the millisecond tick between the timer and the sequencer.
`timescale 1ns/1ps
interface uvpc_tick_if;
  // Restart request, one cycle.
  logic clear;
  // One cycle pulse every millisecond since clear.
  logic tick;
  // Cycles counted since clear, saturating.
  logic [17:0] cycles;
  modport timer (input clear, output tick, output cycles);
  modport user (output clear, input tick, input cycles);
endinterface : uvpc_tick_if

/* design/uvpc_timer.sv */
// Divider producing millisecond tick enables and a short cycle count.
`timescale 1ns/1ps
module uvpc_timer #(
  parameter int TICK_LEN = uvpc_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  uvpc_tick_if.timer tk
);

  // Divider counter and its next value.
  logic [17:0] div_r;
  logic [17:0] div_nxt;
  // Tick flop and next value.
  logic tick_r;
  logic tick_nxt;
  // Saturating cycle count since the last clear, independent of the tick period.
  logic [17:0] cyc_r;
  logic [17:0] cyc_nxt;

  // Next divider value: restart on clear, wrap every tick period.
  always_comb
  begin
    tick_nxt = 1'b0;
    div_nxt = div_r + 18'h00001;
    // The count stops at all ones so that a long wait never wraps back below a limit.
    cyc_nxt = (cyc_r == 18'h3FFFF) ? cyc_r : cyc_r + 18'h00001;
    if (tk.clear)
    begin
      div_nxt = 18'h00000;
      cyc_nxt = 18'h00000;
    end
    else if (div_r == 18'(TICK_LEN - 1))
    begin
      // Period elapsed; emit one tick.
      div_nxt = 18'h00000;
      tick_nxt = 1'b1;
    end
  end

  // Registers of the divider.
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      div_r <= 18'h00000;
      tick_r <= 1'b0;
      cyc_r <= 18'h00000;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  assign tk.tick = tick_r;
  assign tk.cycles = cyc_r;

endmodule : uvpc_timer

/* sim/testbench.sv */
// Self-checking bench for the EPROM programmer controller.
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 50;
  localparam logic [7:0] MAKER = 8'h3A;
  localparam logic [7:0] DEV_CODE = 8'hC5;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic prog_go = 1'b0;
  logic read_go = 1'b0;
  logic id_go = 1'b0;
  logic id_sel = 1'b0;
  logic [14:0] addr = 15'h0000;
  logic [7:0] data = 8'h00;
  logic busy, done, fail, cs_n, oe_n, hv, dq_oe, vpp, vcc;
  logic [4:0] pulses;
  logic [7:0] rdata, dq, q, bus;
  logic [14:0] ma;
  int errors = 0;
  int total_checks = 0;
  // Data pins: the controller wins while enabled, else the memory drives.
  assign bus = dq_oe ? dq : q;
  initial forever #2.5 ref_clk = ~ref_clk;
  uvpc_programmer #(.TICK_LEN(TICK)) uvpc_programmer_inst (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .prog_start_i(prog_go), .read_start_i(read_go), .id_start_i(id_go), .id_sel_i(id_sel), .addr_i(addr),
    .data_i(data), .mem_data_i(bus), .busy_o(busy), .done_o(done), .fail_o(fail), .rdata_o(rdata),
    .pulses_o(pulses), .chip_sel_n_o(cs_n), .out_gate_n_o(oe_n), .mem_addr_o(ma), .id_hv_en_o(hv),
    .mem_data_o(dq), .mem_data_oe_o(dq_oe), .vpp_high_o(vpp), .vcc_prog_o(vcc));
  uvpc_eprom_model #(.MAKER_CODE(MAKER), .TYPE_CODE(DEV_CODE)) uvpc_eprom_model_inst (.chip_sel_n_i(cs_n),
    .out_gate_n_i(oe_n), .addr_i(ma), .id_hv_i(hv), .vpp_high_i(vpp), .data_i(bus), .data_o(q));
  // A second part on the same pins whose select stays high.
  uvpc_eprom_model uvpc_eprom_model_inst2 (.chip_sel_n_i(1'b1), .out_gate_n_i(oe_n), .addr_i(ma),
    .id_hv_i(hv), .vpp_high_i(vpp), .data_i(bus), .data_o());
  // Print the counts and the verdict, then stop.
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // Compare one result with its expected value.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Start one operation (0 program, 1 read, 2 identifier) and wait for done.
  task automatic run_op(input int k, input logic [14:0] a, input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge ref_clk);
    addr <= a;
    data <= d;
    id_sel <= s;
    prog_go <= (k == 0);
    read_go <= (k == 1);
    id_go <= (k == 2);
    @(posedge ref_clk);
    prog_go <= 1'b0;
    read_go <= 1'b0;
    id_go <= 1'b0;
    while (done !== 1'b1 && n < 40000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (done !== 1'b1)
    begin
      errors++;
      print_verdict();
    end
  endtask : run_op
  // Program a byte the memory takes after n pulses and judge the outcome.
  task automatic t_prog(input logic [14:0] a, input logic [7:0] d, input int n, input logic f,
    input logic [4:0] p, input logic [7:0] m);
    uvpc_eprom_model_inst.need = n;
    run_op(0, a, d, 1'b0);
    check(fail, f);
    check(pulses, p);
    check(uvpc_eprom_model_inst.mem_r[a], m);
    check(uvpc_eprom_model_inst2.mem_r[a], 8'hFF);
  endtask : t_prog
  // Pins idle after reset.
  task automatic t_reset();
    @(negedge ref_clk);
    check({cs_n, oe_n, vpp, hv, dq_oe, busy, done, fail}, 8'hC0);
    check(dq, 8'hFF);
  endtask : t_reset
  // An untouched byte reads all ones, and both identifier codes come out.
  task automatic t_erased_and_id();
    run_op(1, 15'h0123, 8'h00, 1'b0);
    check(rdata, 8'hFF);
    run_op(2, 15'h0000, 8'h00, 1'b0);
    check(rdata, MAKER);
    run_op(2, 15'h0000, 8'h00, 1'b1);
    check(rdata, DEV_CODE);
  endtask : t_erased_and_id
  // One pulse suffices; the byte then reads back at 5 V.
  task automatic t_single();
    t_prog(15'h0010, 8'hA5, 1, 1'b0, 5'h01, 8'hA5);
    run_op(1, 15'h0010, 8'h00, 1'b0);
    check(rdata, 8'hA5);
  endtask : t_single
  // Slow bytes: three pulses, then the full allowance of 25.
  task automatic t_multi();
    t_prog(15'h0011, 8'h3C, 3, 1'b0, 5'h03, 8'h3C);
    t_prog(15'h0012, 8'h0F, 25, 1'b0, 5'h19, 8'h0F);
  endtask : t_multi
  // Writing ones over zeros cannot verify and ends in failure.
  task automatic t_zero_only();
    t_prog(15'h0010, 8'h5A, 1, 1'b1, 5'h19, 8'h00);
    run_op(1, 15'h0010, 8'h00, 1'b0);
    check(rdata, 8'h00);
  endtask : t_zero_only
  // Hold reset for six cycles, then run every scenario.
  initial
  begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_erased_and_id();
    t_single();
    t_multi();
    t_zero_only();
    print_verdict();
  end
endmodule : testbench

/* sim/uvpc_eprom_model.sv */
// Behavioural EPROM that answers the programmer's pins.
`timescale 1ns/1ps
module uvpc_eprom_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3A, // Arbitrary value.
  parameter logic [7:0] TYPE_CODE = 8'hC5 // Arbitrary value.
) (
  input wire logic chip_sel_n_i,
  input wire logic out_gate_n_i,
  input wire logic [14:0] addr_i,
  input wire logic id_hv_i,
  input wire logic vpp_high_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  // Cell array, erased to all ones.
  logic [7:0] mem_r [32768];
  // Pulses a byte needs before its cells take the data.
  int need = 1;
  // Pulses seen on the current address.
  int cnt_r = 0;
  logic [14:0] last_a_r = 15'h7FFF;
  logic [7:0] last_r = 8'h00;
  logic [7:0] val;
  logic drv;
  initial foreach (mem_r[i]) mem_r[i] = 8'hFF;
  // End of a select pulse: count it and, once enough, clear the zero bits.
  always @(posedge chip_sel_n_i)
  begin
    if (vpp_high_i)
    begin
      cnt_r = (addr_i == last_a_r) ? cnt_r + 1 : 1;
      last_a_r = addr_i;
      if (cnt_r >= need)
        mem_r[addr_i] = mem_r[addr_i] & data_i;
    end
  end
  // Outputs drive in verify, read and identifier modes only.
  assign drv = !out_gate_n_i && (chip_sel_n_i ? vpp_high_i : !vpp_high_i);
  assign val = id_hv_i ? (addr_i[0] ? TYPE_CODE : MAKER_CODE) : mem_r[addr_i];
  // A released bus shows the inverse of the last byte, never a stale match.
  always @*
  begin
    if (drv)
      last_r = val;
  end
  assign data_o = drv ? val : ~last_r;
endmodule : uvpc_eprom_model

/* sim/uvpc_programmer_props.sv */
// Assertion checker on the programmer's ports.
`timescale 1ns/1ps
module uvpc_programmer_props #(
  parameter int TICK_LEN = 200000,
  parameter int MAX_PULSES = 25
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic done_o,
  input wire logic fail_o,
  input wire logic [4:0] pulses_o,
  input wire logic chip_sel_n_o,
  input wire logic out_gate_n_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic id_hv_en_o,
  input wire logic [7:0] mem_data_o,
  input wire logic mem_data_oe_o,
  input wire logic vpp_high_o,
  input wire logic vcc_prog_o
);
  // Cycles that chip select has been low in a row.
  int lo_cnt_r;
  int lo_cnt_nxt;
  // Restart the count while select is high.
  always_comb
  begin
    lo_cnt_nxt = chip_sel_n_o ? 0 : lo_cnt_r + 1;
  end
  // Register the count.
  always_ff @(posedge ref_clk_i)
  begin
    lo_cnt_r <= resetn_i ? lo_cnt_nxt : 0;
  end
  // True when w lies within five percent of n.
  function automatic bit near(int w, int n);
    return 20 * w >= 19 * n && 20 * w <= 21 * n;
  endfunction : near
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  property p_width;
    $rose(chip_sel_n_o) && $past(vpp_high_o) |->
      near(lo_cnt_r, TICK_LEN) || near(lo_cnt_r, 3 * pulses_o * TICK_LEN);
  endproperty
  property p_supply;
    !chip_sel_n_o && vpp_high_o |-> vcc_prog_o && mem_data_oe_o && out_gate_n_o;
  endproperty
  property p_verify;
    !out_gate_n_o && vpp_high_o |-> chip_sel_n_o && !mem_data_oe_o && vcc_prog_o;
  endproperty
  property p_hold;
    mem_data_oe_o && $past(mem_data_oe_o) |-> $stable(mem_addr_o) && $stable(mem_data_o);
  endproperty
  property p_id;
    id_hv_en_o |-> (mem_addr_o & 15'h7DFE) == 15'h0000 && !vpp_high_o;
  endproperty
  property p_read;
    !out_gate_n_o && !chip_sel_n_o |-> !vpp_high_o && !vcc_prog_o;
  endproperty
  property p_fail;
    done_o && fail_o |-> pulses_o == 5'(MAX_PULSES);
  endproperty
  property p_max;
    vpp_high_o |-> pulses_o <= MAX_PULSES;
  endproperty
  property p_vdelay;
    $fell(out_gate_n_o) |-> !out_gate_n_o [*8];
  endproperty
  a_width: assert property (p_width) else $error("pulse width off");
  a_supply: assert property (p_supply) else $error("bad program pins");
  a_verify: assert property (p_verify) else $error("bad verify pins");
  a_hold: assert property (p_hold) else $error("address or data moved");
  a_id: assert property (p_id) else $error("bad identifier pins");
  a_read: assert property (p_read) else $error("readback not at 5 V");
  a_fail: assert property (p_fail) else $error("early failure");
  a_max: assert property (p_max) else $error("too many pulses");
  a_vdelay: assert property (p_vdelay) else $error("gate low too short");
  c_fail: cover property (done_o && fail_o);
  c_over: cover property ($rose(chip_sel_n_o) && lo_cnt_r > 2 * TICK_LEN);
  c_id: cover property (id_hv_en_o && !out_gate_n_o);
endmodule : uvpc_programmer_props
bind uvpc_programmer uvpc_programmer_props #(.TICK_LEN(TICK_LEN), .MAX_PULSES(MAX_PULSES))
  uvpc_programmer_props_inst (.ref_clk_i, .resetn_i, .done_o, .fail_o, .pulses_o, .chip_sel_n_o,
  .out_gate_n_o, .mem_addr_o, .id_hv_en_o, .mem_data_o, .mem_data_oe_o, .vpp_high_o, .vcc_prog_o);
